// *** core/tdl_limiter.sv ***
// Transmit duty-cycle limiter: gates whole transmit transactions, holds
// outbound bytes while sending is blocked.
// Assumes the transmitter raises tx_active for the whole transaction and
// drops it only when the transaction is over; all inputs are synchronous.
`timescale 1ns/1ns

//////////////////////////////////////////////////////////////////////////////
module tdl_limiter
  import tdl_pkg::*;
#(
  parameter int unsigned DUTY_PCT = DUTY_PCT_DEFAULT,
  parameter int unsigned DATA_W   = BUF_W,
  parameter int unsigned DEPTH    = BUF_DEPTH
) (
  // Clock, reset, enable
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              clk_en,
  // Message source side
  input  wire logic [DATA_W-1:0] src_data,
  input  wire logic              src_valid,
  output logic                   src_ready,
  // Transmitter side
  output logic [DATA_W-1:0]      tx_data,
  output logic                   tx_valid,
  input  wire logic              tx_ready,
  output logic                   tx_start,
  input  wire logic              tx_active,
  // Status
  output logic                   tx_blocked,
  output logic [DUR_W-1:0]       last_duration
);

  // Effective duty is clamped so a bad preset cannot exceed the ceiling
  localparam int unsigned DUTY_EFF = (DUTY_PCT > DUTY_PCT_CEILING) ? DUTY_PCT_CEILING :
                                     (DUTY_PCT == 0) ? 1 : DUTY_PCT;
  localparam int unsigned AW       = $clog2(DEPTH);
  localparam logic [7:0]  FACT_NUM = 8'(PCT_FULL - DUTY_EFF);
  localparam logic [7:0]  FACT_DEN = 8'(DUTY_EFF);

  tdl_state_t        state_reg;
  logic [DUR_W-1:0]  dur_reg;
  logic [IDLE_W-1:0] idle_reg;
  logic              act_d_reg;
  logic [DATA_W-1:0] mem [DEPTH];
  logic [AW:0]       wr_reg;
  logic [AW:0]       rd_reg;
  logic              full;
  logic              empty;
  logic              push;
  logic              pop;
  logic              fall;
  logic [AW:0]       fill;

  // Duration times the duty factor, with the division rounded up
  function automatic logic [IDLE_W-1:0] idle_cycles(input logic [DUR_W-1:0] d);
    logic [IDLE_W-1:0] prod;
    prod = IDLE_W'(d) * IDLE_W'(FACT_NUM);
    return (prod + IDLE_W'(FACT_DEN) - IDLE_W'(1)) / IDLE_W'(FACT_DEN);
  endfunction

  assign fall  = act_d_reg & ~tx_active;
  assign full  = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
  assign empty = (wr_reg == rd_reg);
  assign push  = src_valid & src_ready;
  assign pop   = tx_valid & tx_ready;
  // Occupancy taken modulo the pointer width, so it stays right after a wrap
  assign fill  = wr_reg - rd_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Limiter state: a transaction starts only from idle with data queued
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= TDL_IDLE;
    end else if (clk_en) begin
      case (state_reg)
        TDL_IDLE: if (!empty) state_reg <= TDL_SEND;
        TDL_SEND: if (fall) state_reg <= TDL_CALC;
        TDL_CALC: state_reg <= TDL_WAIT;
        TDL_WAIT: if (idle_reg <= IDLE_W'(1)) state_reg <= TDL_IDLE;
        default:  state_reg <= TDL_IDLE;
      endcase
    end
  end

  // Edge history of the transmitter's activity
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      act_d_reg <= 1'b0;
    end else if (clk_en) begin
      act_d_reg <= tx_active;
    end
  end

  // Duration counter; restarts with each transaction, kept after it ends
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dur_reg <= '0;
    end else if (clk_en) begin
      if (state_reg == TDL_IDLE && !empty) begin
        dur_reg <= '0;
      end else if (state_reg == TDL_SEND && tx_active && dur_reg != '1) begin
        dur_reg <= dur_reg + DUR_W'(1);
      end
    end
  end

  // Idle interval load and count-down; saturating duration avoids wrap
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      idle_reg <= '0;
    end else if (clk_en) begin
      if (state_reg == TDL_CALC) begin
        idle_reg <= idle_cycles(dur_reg);
      end else if (state_reg == TDL_WAIT && idle_reg != '0) begin
        idle_reg <= idle_reg - IDLE_W'(1);
      end
    end
  end

  // Registered status and transaction start strobe
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_start      <= 1'b0;
      tx_blocked    <= 1'b0;
      last_duration <= '0;
    end else if (clk_en) begin
      tx_start   <= (state_reg == TDL_IDLE) && !empty;
      tx_blocked <= (state_reg == TDL_CALC) || (state_reg == TDL_WAIT && idle_reg > IDLE_W'(1));
      if (state_reg == TDL_CALC) last_duration <= dur_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Holding buffer: bytes are only drained while a transaction is granted
  always_ff @(posedge clock) begin
    if (clk_en && push) mem[wr_reg[AW-1:0]] <= src_data;
  end

  // Buffer pointers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else if (clk_en) begin
      if (push) wr_reg <= wr_reg + (AW+1)'(1);
      if (pop) rd_reg <= rd_reg + (AW+1)'(1);
    end
  end

  // Registered handshake outputs, looked ahead one cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      src_ready <= 1'b0;
      tx_valid  <= 1'b0;
      tx_data   <= '0;
    end else if (clk_en) begin
      src_ready <= ({1'b0, fill} + (AW+2)'(push) - (AW+2)'(pop)) < (AW+2)'(DEPTH - 1);
      tx_valid  <= 1'b0;
      if (state_reg == TDL_SEND && !fall && !(pop && (rd_reg + (AW+1)'(1)) == wr_reg) && !empty) begin
        tx_valid <= 1'b1;
        tx_data  <= pop ? mem[rd_reg[AW-1:0] + AW'(1)] : mem[rd_reg[AW-1:0]];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_NO_START_WHILE_WAIT: assert property (@(posedge clock) disable iff (!rst_n)
    (state_reg == TDL_WAIT && idle_reg > IDLE_W'(1)) |-> !tx_start)
    else $error("start issued during idle interval");
  AST_IDLE_LOAD: assert property (@(posedge clock) disable iff (!rst_n)
    (clk_en && state_reg == TDL_CALC) |=> idle_reg == idle_cycles($past(dur_reg)))
    else $error("idle interval wrong");
  AST_DUR_KEPT: assert property (@(posedge clock) disable iff (!rst_n)
    (clk_en && state_reg == TDL_CALC) |=> last_duration == $past(dur_reg))
    else $error("duration not kept");
  // Idle must be long enough that send plus idle never tops the ceiling
  AST_CEILING: assert property (@(posedge clock) disable iff (!rst_n)
    (clk_en && state_reg == TDL_CALC) |=>
      64'(idle_reg) * 64'(DUTY_PCT_CEILING) >= 64'($past(dur_reg)) * 64'(PCT_FULL - DUTY_PCT_CEILING))
    else $error("duty above ceiling");
  AST_NO_CUT: assert property (@(posedge clock) disable iff (!rst_n)
    (state_reg == TDL_SEND && tx_active) |=> state_reg == TDL_SEND)
    else $error("transaction cut short");
  AST_HOLD_BLOCKED: assert property (@(posedge clock) disable iff (!rst_n)
    (state_reg == TDL_WAIT) |=> !tx_valid)
    else $error("data released while blocked");
  AST_FULL_STALL: assert property (@(posedge clock) disable iff (!rst_n)
    full |-> !src_ready)
    else $error("ready while full");
  // A frozen cycle holds the strobe, so only enabled cycles count here
  AST_START_ONCE: assert property (@(posedge clock) disable iff (!rst_n)
    (clk_en && tx_start) |=> !tx_start)
    else $error("start longer than a cycle");
  // Loaded idle follows the fixed preset factor, rounded up by less than one
  AST_FIXED_PRESET: assert property (@(posedge clock) disable iff (!rst_n)
    (clk_en && state_reg == TDL_CALC) |=>
      (64'(idle_reg) * 64'(FACT_DEN) >= 64'($past(dur_reg)) * 64'(FACT_NUM)) &&
      (64'(idle_reg) * 64'(FACT_DEN) < 64'($past(dur_reg)) * 64'(FACT_NUM) + 64'(FACT_DEN)))
    else $error("idle interval does not follow the preset");
  AST_VALID_IN_SEND: assert property (@(posedge clock) disable iff (!rst_n)
    tx_valid |-> state_reg == TDL_SEND)
    else $error("byte offered outside a granted transaction");
  AST_BLOCK_AFTER: assert property (@(posedge clock) disable iff (!rst_n)
    (clk_en && state_reg == TDL_CALC) |=> tx_blocked)
    else $error("not blocked after a transaction");

  COV_TRANSACTION: cover property (@(posedge clock) disable iff (!rst_n) tx_start ##[1:20] fall);
  COV_WAIT_DONE:   cover property (@(posedge clock) disable iff (!rst_n)
    state_reg == TDL_WAIT ##1 state_reg == TDL_IDLE);
  COV_FULL:        cover property (@(posedge clock) disable iff (!rst_n) full);
  COV_FROZEN_SEND: cover property (@(posedge clock) disable iff (!rst_n)
    !clk_en && state_reg == TDL_SEND && tx_active);

endmodule

// *** dv/tb.sv ***
// Self-checking bench for the duty-cycle limiter.
// Assumes the transmitter model answers every grant.
`timescale 1ns/1ns
module tb;
  import tdl_pkg::*;
  localparam int DUTY = 50; // Above the ceiling, so the clamp shows
  localparam int DC   = (DUTY > int'(DUTY_PCT_CEILING)) ? int'(DUTY_PCT_CEILING) : DUTY;
  logic             clock = 1'b0;
  logic             rst_n = 1'b0;
  logic             clk_en = 1'b1;
  logic             src_valid = 1'b0;
  logic [7:0]       src_data = 8'h00;
  logic             src_ready, tx_valid, tx_ready, tx_start, tx_active, tx_blocked;
  logic [7:0]       tx_data;
  logic [DUR_W-1:0] last_duration;
  int               failures = 0, num_checks = 0, act = 0, blk = 0, dur = 0, n;
  logic [7:0]       q[$];
  always #20 clock = ~clock;
  // Random enable drops check that every state freezes together
  always @(posedge clock) clk_en <= ($urandom % 8) != 0;
  tdl_limiter #(.DUTY_PCT(DUTY)) tdl_limiter_inst (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
    .src_data(src_data), .src_valid(src_valid), .src_ready(src_ready), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_start(tx_start), .tx_active(tx_active),
    .tx_blocked(tx_blocked), .last_duration(last_duration));
  tdl_tx_model tdl_tx_model_inst (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .tx_start(tx_start),
    .tx_ready(tx_ready), .tx_active(tx_active));
  //////////////////////////////////////////////////////////////////////////////
  // Comparison and closing
  task automatic chk(input bit ok, input string msg);
    num_checks++;
    if (!ok) begin
      failures++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Reference model: byte queue, burst length, idle length
  always @(posedge clock) if (rst_n && clk_en) begin
    if (src_valid && src_ready === 1'b1) q.push_back(src_data);
    if (tx_valid === 1'b1 && tx_ready) begin
      chk(q.size() > 0 && tx_data === q[0], "byte order");
      if (q.size() > 0) void'(q.pop_front());
    end
    chk(!(tx_blocked === 1'b1 && (tx_valid !== 1'b0 || tx_start !== 1'b0)), "sent while blocked");
    if (tx_active) act++;
    else if (act != 0) begin
      dur = act;
      act = 0;
    end
    if (tx_blocked === 1'b1) begin
      if (blk == 0) chk(last_duration === DUR_W'(dur), "duration");
      blk++;
    end else if (blk != 0) begin
      chk(blk == (dur * (int'(PCT_FULL) - DC) + DC - 1) / DC, "idle length");
      blk = 0;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Stimulus: bursts of bytes, many landing while blocked
  initial begin
    void'($urandom(32'h41484c20));
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    for (int i = 0; i < 60; i++) begin
      src_valid <= 1'b1;
      src_data  <= 8'($urandom);
      for (n = 0; n < 5000; n++) begin
        @(posedge clock);
        if (src_ready && clk_en) break;
      end
      if (n == 5000) begin
        failures++;
        print_verdict();
      end
      if ($urandom % 4 == 0) begin
        src_valid <= 1'b0;
        repeat (1 + $urandom % 40) @(posedge clock);
      end
    end
    src_valid <= 1'b0;
    for (n = 0; n < 20000; n++) begin
      @(posedge clock);
      if (q.size() == 0 && blk == 0 && tx_active === 1'b0 && tx_blocked === 1'b0) break;
    end
    if (n == 20000) failures++;
    repeat (3) @(posedge clock);
    print_verdict();
  end
endmodule

// *** dv/tdl_tx_model.sv ***
// Transmitter model: runs one transaction for each grant pulse.
// Assumes grants are one-cycle pulses on the limiter clock.
`timescale 1ns/1ns
module tdl_tx_model (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic clk_en,
  // Limiter side
  input  wire logic tx_start,
  output logic      tx_ready,
  output logic      tx_active
);
  int dly;
  int run;
  //////////////////////////////////////////////////////////////////////////////
  // Late rise after a grant, random length, random stalls on bytes
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dly       <= 0;
      run       <= 0;
      tx_active <= 1'b0;
      tx_ready  <= 1'b0;
    end else if (clk_en) begin
      tx_ready <= tx_active && ($urandom % 3 != 0); // Stalls test the hold
      if (tx_start)
        dly <= 1 + $urandom % 3;
      else if (dly != 0)
        dly <= dly - 1;
      if (dly == 1) begin
        tx_active <= 1'b1;
        run       <= 4 + $urandom % 30;
      end else if (run != 0) begin
        run       <= run - 1;
        tx_active <= (run != 1);
      end
    end
  end
endmodule

// *** pkg/tdl_pkg.sv ***
// Constants and types for the transmit duty-cycle limiter.
// Assumes a single 25 MHz clock domain; no software-visible registers.
package tdl_pkg;

  // Clock rate
  localparam int unsigned CLK_PERIOD_NS    = 40;
  localparam int unsigned CLK_HZ           = 1000000000 / CLK_PERIOD_NS;

  // Duty-cycle arithmetic, in percent
  localparam int unsigned PCT_FULL         = 100;
  localparam int unsigned DUTY_PCT_DEFAULT = 10;
  localparam int unsigned DUTY_PCT_CEILING = 30;

  // Counter widths
  localparam int unsigned DUR_W            = 32;
  localparam int unsigned IDLE_W           = 40;

  // Outbound holding buffer
  localparam int unsigned BUF_W            = 8;
  localparam int unsigned BUF_DEPTH        = 16;

  // Limiter states, Gray coded along idle -> send -> compute -> wait
  typedef enum logic [1:0] {
    TDL_IDLE = 2'b00,
    TDL_SEND = 2'b01,
    TDL_CALC = 2'b11,
    TDL_WAIT = 2'b10
  } tdl_state_t;

endpackage
